// ==== ppm_pkg.sv ====
// Package of constants and types for the port 2 pin mode configuration block
package ppm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned       PPM_ADDR_W      = 8;
  localparam logic [7:0]        PPM_ACCESS_ADDR = 8'h97;
  localparam logic [7:0]        PPM_RESET_VAL   = 8'h00;
  localparam int unsigned       PPM_NUM_PINS    = 8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned       PPM_MODE_HI     = 7;
  localparam int unsigned       PPM_MODE_LO     = 5;
  localparam int unsigned       PPM_IN_HI       = 6;
  localparam int unsigned       PPM_DIR_BIT     = 4;
  localparam int unsigned       PPM_LOAD_BIT    = 3;
  localparam int unsigned       PPM_IDX_HI      = 2;
  localparam int unsigned       PPM_IDX_LO      = 0;

  // ****************************************************************
  // Mode encodings
  // ****************************************************************
  localparam logic [2:0]        PPM_OUT_NORMAL  = 3'h0;
  localparam logic [2:0]        PPM_OUT_HIGH    = 3'h3;
  localparam logic [1:0]        PPM_IN_NOPULL   = 2'h0;
  localparam logic [1:0]        PPM_IN_PULLDOWN = 2'h1;
  localparam logic [1:0]        PPM_IN_PULLUP   = 2'h2;
  localparam logic [1:0]        PPM_IN_OFF      = 2'h3;
  localparam logic              PPM_DIR_OUT     = 1'b0;
  localparam logic              PPM_DIR_IN      = 1'b1;

  // Block state: modes of all pins, read pointer, read data
  typedef struct packed {
    logic [7:0][2:0] out_mode;
    logic [7:0][1:0] in_mode;
    logic [2:0]      rd_idx;
    logic            rd_dir;
    logic [7:0]      rdata;
  } ppm_state_t;

endpackage

// ==== ppm_port2_pin_mode.sv ====
// Port 2 pin mode configuration register with indirect pin addressing
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Operation
// - output modes: 000 normal, 011 high drive
// - input modes: no pull, pull-down, pull-up, off
// - direction bit zero output, one input
// - pin index selects pin for write
// - load bit clear writes selected pin mode
// - load bit set stores index and direction
// - read returns mode of stored pin, direction
// - index codes 0 to 7 select pins 0-7
// ****************************************************************
// ****************************************************************
// Register layout
// ****************************************************************
// One byte at the access address:
//   [7:5] mode field: output mode, or input mode in [6:5]
//   [4]   direction select: zero output side, one input side
//   [3]   read pointer load: set stores index and direction only
//   [2:0] pin index, binary, pin 0 to pin 7
// A read returns the mode of the pin that the stored pointer names;
// bits 4 to 0 and, for the input side, bit 7 read as zero.
// Illegal output codes are kept as written and flagged per pin, so
// software can see its own mistake instead of a silent rewrite.
// Read data stand for the single cycle after the read strobe and are
// zero otherwise, so a wired-or read mux upstream stays clean.
module ppm_port2_pin_mode
  import ppm_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  // Register port
  input  wire logic [PPM_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // Pin configuration outputs, one field per pin
  output logic      [7:0]            high_drive_o,
  output logic      [7:0]            illegal_out_mode_o,
  output logic      [7:0]            pull_down_o,
  output logic      [7:0]            pull_up_o,
  output logic      [7:0]            in_buf_en_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  ppm_state_t state_ff;
  ppm_state_t nxt_state;

  logic       wr_hit;
  logic       rd_hit;
  logic [2:0] w_idx;
  logic       w_dir;
  logic       w_load;
  logic [2:0] w_mode;

  // Mode of the pin that the read pointer names, for the read checks
  logic [2:0] sel_out_mode;
  logic [1:0] sel_in_mode;

  // Read-back value for a pin and direction
  function automatic logic [7:0] ppm_readback(input ppm_state_t s,
                                              input logic [2:0] idx,
                                              input logic       dir);
    logic [7:0] v;
    v = '0;
    if (dir == PPM_DIR_IN) begin
      v[PPM_IN_HI:PPM_MODE_LO] = s.in_mode[idx];
    end else begin
      v[PPM_MODE_HI:PPM_MODE_LO] = s.out_mode[idx];
    end
    return v;
  endfunction

  // Decode of the register port
  assign wr_hit = wr_i && (addr_i == PPM_ACCESS_ADDR);
  assign rd_hit = rd_i && (addr_i == PPM_ACCESS_ADDR);
  assign w_idx  = wdata_i[PPM_IDX_HI:PPM_IDX_LO];
  assign w_dir  = wdata_i[PPM_DIR_BIT];
  assign w_load = wdata_i[PPM_LOAD_BIT];
  assign w_mode = wdata_i[PPM_MODE_HI:PPM_MODE_LO];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    // A pointer load and a mode write are exclusive by the load bit,
    // so one write never both moves the pointer and edits a pin.
    // Illegal output codes go in unchanged; the decode flags them.
    if (wr_hit) begin
      if (w_load) begin
        nxt_state.rd_idx = w_idx;
        nxt_state.rd_dir = w_dir;
      end else if (w_dir == PPM_DIR_IN) begin
        nxt_state.in_mode[w_idx] = w_mode[1:0];
      end else begin
        nxt_state.out_mode[w_idx] = w_mode;
      end
    end
    // Unmapped reads return zero; data stands one cycle only
    nxt_state.rdata = '0;
    if (rd_hit) begin
      nxt_state.rdata = ppm_readback(state_ff, state_ff.rd_idx,
                                     state_ff.rd_dir);
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o = state_ff.rdata;

  // Pointer-selected modes, watched by the read-back assertions
  assign sel_out_mode = state_ff.out_mode[state_ff.rd_idx];
  assign sel_in_mode  = state_ff.in_mode[state_ff.rd_idx];

  // ****************************************************************
  // Pin configuration decode
  // ****************************************************************
  // Decoded from the stored modes only, so the pin controls change
  // exactly at the write edge and never glitch on a read.
  // Each pin reads only its own fields; the index is plain binary.
  always_comb begin
    for (int p = 0; p < PPM_NUM_PINS; p++) begin
      high_drive_o[p]       = state_ff.out_mode[p] == PPM_OUT_HIGH;
      illegal_out_mode_o[p] = (state_ff.out_mode[p] != PPM_OUT_HIGH)
                           && (state_ff.out_mode[p] != PPM_OUT_NORMAL);
      pull_down_o[p]        = state_ff.in_mode[p] == PPM_IN_PULLDOWN;
      pull_up_o[p]          = state_ff.in_mode[p] == PPM_IN_PULLUP;
      in_buf_en_o[p]        = state_ff.in_mode[p] != PPM_IN_OFF;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // Read data fall back to zero in any cycle not after a read
  a_rdata_idle_zero: assert property (
      !rd_hit |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  // Write-only fields never leak into the read data
  a_rd_low_bits: assert property (
      rd_hit |=> rdata_o[4:0] == 5'h00)
    else $error("write-only bits read nonzero");

  // A mode write on the output side lands in the indexed pin
  a_wr_out_mode: assert property (
      wr_hit && !w_load && !w_dir
      |=> state_ff.out_mode[$past(w_idx)] == $past(w_mode))
    else $error("output mode not written");

  // A mode write on the input side keeps only the two low mode bits
  a_wr_in_mode: assert property (
      wr_hit && !w_load && w_dir
      |=> state_ff.in_mode[$past(w_idx)] == $past(w_mode[1:0]))
    else $error("input mode not written");

  // A pointer load must not disturb any pin setting
  a_ptr_load_keeps: assert property (
      wr_hit && w_load
      |=> $stable(state_ff.out_mode) && $stable(state_ff.in_mode))
    else $error("pointer load changed a pin mode");

  // A pointer load stores index and direction for later reads
  a_ptr_load_store: assert property (
      wr_hit && w_load
      |=> state_ff.rd_idx == $past(w_idx)
          && state_ff.rd_dir == $past(w_dir))
    else $error("read pointer not stored");

  // Input-side pointer load, then a read of that pin
  a_load_then_read: assert property (
      wr_hit && w_load && w_dir ##1 rd_hit && !wr_hit
      |=> rdata_o[6:5] == state_ff.in_mode[$past(w_idx, 2)]
          && !rdata_o[7])
    else $error("read after pointer load wrong");

  // Output-side pointer load, then a read of that pin
  a_load_rd_out: assert property (
      wr_hit && w_load && !w_dir ##1 rd_hit && !wr_hit
      |=> rdata_o[7:5] == state_ff.out_mode[$past(w_idx, 2)])
    else $error("output read after pointer load wrong");

  // High drive reaches the pin that the index names
  a_high_drive_pin: assert property (
      wr_hit && !w_load && !w_dir && w_mode == PPM_OUT_HIGH
      |=> high_drive_o[$past(w_idx)])
    else $error("high drive not applied to indexed pin");

  // Direction one steers the write to the input side
  a_pull_up_pin: assert property (
      wr_hit && !w_load && w_dir && w_mode[1:0] == PPM_IN_PULLUP
      |=> pull_up_o[$past(w_idx)])
    else $error("pull-up not applied to indexed pin");

  // A write to another address leaves every setting alone
  a_unmapped_wr_keeps: assert property (
      wr_i && !wr_hit
      |=> $stable(state_ff.out_mode) && $stable(state_ff.in_mode)
          && $stable(state_ff.rd_idx) && $stable(state_ff.rd_dir))
    else $error("write to another address changed state");

  // A read of another address returns zero
  a_unmapped_rd_zero: assert property (
      rd_i && !rd_hit |=> rdata_o == 8'h00)
    else $error("read of another address not zero");

  // Output-side writes leave the input side and the pointer alone
  a_out_wr_keeps_in: assert property (
      wr_hit && !w_load && w_dir == PPM_DIR_OUT
      |=> $stable(state_ff.in_mode) && $stable(state_ff.rd_idx)
          && $stable(state_ff.rd_dir))
    else $error("output write touched input side");

  // Input-side writes leave the output side and the pointer alone
  a_in_wr_keeps_out: assert property (
      wr_hit && !w_load && w_dir == PPM_DIR_IN
      |=> $stable(state_ff.out_mode) && $stable(state_ff.rd_idx)
          && $stable(state_ff.rd_dir))
    else $error("input write touched output side");

  // Output-side read returns the mode of the pointed pin
  a_rd_out_mode: assert property (
      rd_hit && state_ff.rd_dir == PPM_DIR_OUT
      |=> rdata_o[7:5] == $past(sel_out_mode))
    else $error("output mode read back wrong");

  // Input-side read returns two bits with the top mode bit clear
  a_rd_in_mode: assert property (
      rd_hit && state_ff.rd_dir == PPM_DIR_IN
      |=> rdata_o[7:5] == {1'b0, $past(sel_in_mode)})
    else $error("input mode read back wrong");

  // Normal drive clears both high drive and the illegal flag
  a_normal_drive_pin: assert property (
      wr_hit && !w_load && !w_dir && w_mode == PPM_OUT_NORMAL
      |=> !high_drive_o[$past(w_idx)]
          && !illegal_out_mode_o[$past(w_idx)])
    else $error("normal drive not applied to indexed pin");

  // Any other output code is kept and flagged as illegal
  a_illegal_out_flag: assert property (
      wr_hit && !w_load && !w_dir && w_mode != PPM_OUT_NORMAL
      && w_mode != PPM_OUT_HIGH
      |=> illegal_out_mode_o[$past(w_idx)] && !high_drive_o[$past(w_idx)])
    else $error("illegal output code not flagged");

  // Pull-down keeps the buffer on and the pull-up off
  a_pull_down_pin: assert property (
      wr_hit && !w_load && w_dir && w_mode[1:0] == PPM_IN_PULLDOWN
      |=> pull_down_o[$past(w_idx)] && !pull_up_o[$past(w_idx)]
          && in_buf_en_o[$past(w_idx)])
    else $error("pull-down not applied to indexed pin");

  // Buffer off also drops both pulls
  a_in_off_pin: assert property (
      wr_hit && !w_load && w_dir && w_mode[1:0] == PPM_IN_OFF
      |=> !in_buf_en_o[$past(w_idx)] && !pull_up_o[$past(w_idx)]
          && !pull_down_o[$past(w_idx)])
    else $error("input buffer not switched off");

  // No-pull mode keeps the buffer on with both pulls off
  a_no_pull_pin: assert property (
      wr_hit && !w_load && w_dir && w_mode[1:0] == PPM_IN_NOPULL
      |=> in_buf_en_o[$past(w_idx)] && !pull_up_o[$past(w_idx)]
          && !pull_down_o[$past(w_idx)])
    else $error("no-pull mode not applied");

  // Both pulls on one pin would fight each other
  a_pull_exclusive: assert property (
      (pull_up_o & pull_down_o) == 8'h00)
    else $error("pull-up and pull-down both on");

  // A pin is never both high drive and illegal
  a_drive_exclusive: assert property (
      (high_drive_o & illegal_out_mode_o) == 8'h00)
    else $error("high drive on an illegal code");

  // Without a hit write the settings and pointer hold
  a_idle_keeps_state: assert property (
      !wr_hit
      |=> $stable(state_ff.out_mode) && $stable(state_ff.in_mode)
          && $stable(state_ff.rd_idx) && $stable(state_ff.rd_dir))
    else $error("state changed without a write");

  // Main scenarios: pointer then read, high drive, input off, illegal output code, back to back
  c_ptr_then_read: cover property (wr_hit && w_load ##1 rd_hit);
  c_out_high: cover property (wr_hit && !w_load && !w_dir
                              && w_mode == PPM_OUT_HIGH);
  c_in_off: cover property (wr_hit && !w_load && w_dir
                            && w_mode[1:0] == PPM_IN_OFF);
  c_wr_rd_b2b: cover property (wr_hit ##1 rd_hit);
  c_out_illegal: cover property (wr_hit && !w_load && !w_dir
                                 && w_mode == 3'h5);

endmodule // ppm_port2_pin_mode
`default_nettype wire

// ==== port2_pin_mode_config_tb.sv ====
// Self-checking testbench for the port 2 pin mode configuration block
`timescale 1ns/1ps
`default_nettype none
module port2_pin_mode_config_tb;
  import ppm_pkg::*;
  // ****************************************************************
  // Signals and reference model state
  // ****************************************************************
  logic       core_clk_i  = 1'b0;
  logic       resetn_i    = 1'b0;
  logic [7:0] addr_i      = 8'h00;
  logic [7:0] wdata_i     = 8'h00;
  logic       wr_i        = 1'b0;
  logic       rd_i        = 1'b0;
  logic [7:0] rdata_o, high_drive_o, illegal_out_mode_o;
  logic [7:0] pull_down_o, pull_up_o, in_buf_en_o;
  logic [7:0] ehd, eil, epd, epu, ebe;
  logic [31:0] r;
  int         mismatches  = 0;
  int         check_count = 0;
  int         seed        = 32'h03bafba3;
  int         om [8]      = '{default: 0};
  int         im [8]      = '{default: 0};
  int         pidx        = 0;
  int         pdir        = 0;

  // Clock, 20 ns period
  always #10 core_clk_i = ~core_clk_i;

  ppm_port2_pin_mode i_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .high_drive_o(high_drive_o), .illegal_out_mode_o(illegal_out_mode_o),
    .pull_down_o(pull_down_o), .pull_up_o(pull_up_o),
    .in_buf_en_o(in_buf_en_o));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Model update, one bus cycle, then read data and pin outputs compared
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] er;
    er = 8'h00;
    if (!w && a == PPM_ACCESS_ADDR) begin
      er = pdir ? {1'b0, 2'(im[pidx]), 5'h00} : {3'(om[pidx]), 5'h00};
    end
    if (w && a == PPM_ACCESS_ADDR) begin
      if (d[3]) begin
        pidx = int'(d[2:0]);
        pdir = int'(d[4]);
      end else if (d[4]) begin
        im[d[2:0]] = int'(d[6:5]);
      end else begin
        om[d[2:0]] = int'(d[7:5]);
      end
    end
    @(posedge core_clk_i);
    wr_i    <= w;
    rd_i    <= !w;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    if (!w) chk(rdata_o, er);
    for (int i = 0; i < 8; i++) begin
      ehd[i] = (om[i] == 3);
      eil[i] = (om[i] != 0) && (om[i] != 3);
      epd[i] = (im[i] == 1);
      epu[i] = (im[i] == 2);
      ebe[i] = (im[i] != 3);
    end
    chk(high_drive_o, ehd);
    chk(illegal_out_mode_o, eil);
    chk(pull_down_o, epd);
    chk(pull_up_o, epu);
    chk(in_buf_en_o, ebe);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    acc(1'b0, PPM_ACCESS_ADDR, 8'h00);
    $display("Reset test done");
    // Every output and input code, each on its own pin
    for (int p = 0; p < 8; p++) begin
      acc(1'b1, PPM_ACCESS_ADDR, {3'(p), 2'b00, 3'(p)});
      acc(1'b1, PPM_ACCESS_ADDR, {1'b1, 2'(p), 2'b10, 3'(7 - p)});
    end
    $display("Mode write test done");
    // Pointer loads on both sides with mode field 7 minus the index, then read back
    for (int p = 0; p < 16; p++) begin
      acc(1'b1, PPM_ACCESS_ADDR, {3'h7 - 3'(p), 1'(p >> 3), 1'b1, 3'(p)});
      acc(1'b0, PPM_ACCESS_ADDR, 8'h00);
    end
    $display("Read back test done");
    // Random traffic, unmapped addresses among it
    repeat (300) begin
      r = $random(seed);
      acc(r[0], r[1] ? PPM_ACCESS_ADDR : r[15:8], r[23:16]);
    end
    $display("Random test done");
    end_of_test;
  end

  // Watchdog well beyond the expected run of about 710 cycles
  initial begin
    #(20 * 3000);
    mismatches++;
    $display("Watchdog expired");
    end_of_test;
  end
endmodule // port2_pin_mode_config_tb
`default_nettype wire
